// ### adcscr_host.sv
`timescale 1ns/100ps
// serial host model: sclk idles low, 4 mclk per phase, all changes on the mclk fall
module adcscr_host (
    input  wire logic mclk,      // system clock
    output logic      spi_cs_n,  // select, active low
    output logic      spi_sclk,  // serial clock
    output logic      spi_sdi,   // data to device
    input  wire logic spi_sdo,   // data from device
    input  wire logic spi_sdo_oe // device drives sdo
);
    logic [7:0] tx [4]; // bytes to send
    logic [7:0] rx [4]; // bytes seen

    // idle bus before the first frame
    initial
    begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_sdi  = 1'b0;
    end

    // one whole frame: instruction then n bytes, msb first
    // sdo is only trusted while the device says it drives it, else x so a compare fails
    task automatic xfer(input logic rd, input logic [14:0] addr, input int n);
        logic [15:0] ins;
        ins = {rd, addr};
        @(negedge mclk);
        spi_cs_n = 1'b0;
        for (int i = 0; i < 16 + 8 * n; i++)
        begin
            spi_sdi = (i < 16) ? ins[15 - i] : tx[(i - 16) / 8][7 - (i % 8)];
            repeat (4) @(negedge mclk);
            spi_sclk = 1'b1;
            if (i >= 16)
                rx[(i - 16) / 8][7 - (i % 8)] = spi_sdo_oe ? spi_sdo : 1'bx;
            repeat (4) @(negedge mclk);
            spi_sclk = 1'b0;
        end
        repeat (4) @(negedge mclk);
        spi_cs_n = 1'b1;
        spi_sdi  = ~spi_sdi; // released line shows no stale level
        repeat (4) @(negedge mclk);
    endtask
endmodule

// ### adcscr_pkg.sv
package adcscr_pkg;
    // serial access framing
    localparam int          ADDR_W          = 15;
    localparam logic [3:0]  INSTR_LAST_BIT  = 4'hF;
    localparam logic [3:0]  BYTE_LAST_BIT   = 4'h7;

    // register byte addresses
    localparam logic [14:0] OFS_SERIAL_CFG  = 15'h0010;
    localparam logic [14:0] OFS_CLK_SYSREF  = 15'h0029;
    localparam logic [14:0] OFS_CLK_MODE    = 15'h002A;
    localparam logic [14:0] OFS_POS_B0      = 15'h002C;
    localparam logic [14:0] OFS_POS_B1      = 15'h002D;
    localparam logic [14:0] OFS_POS_B2      = 15'h002E;
    localparam logic [14:0] OFS_SPAN_A_B0   = 15'h0030;
    localparam logic [14:0] OFS_SPAN_A_B1   = 15'h0031;
    localparam logic [14:0] OFS_SPAN_B_B0   = 15'h0032;
    localparam logic [14:0] OFS_SPAN_B_B1   = 15'h0033;
    localparam logic [14:0] OFS_REF_SRC     = 15'h0038;
    localparam logic [14:0] OFS_TSTAMP      = 15'h003B;

    // values after reset
    localparam logic [7:0]  RST_SERIAL_CFG  = 8'h00;
    localparam logic [7:0]  RST_CLK_SYSREF  = 8'h00;
    localparam logic [7:0]  RST_CLK_MODE    = 8'h20;
    localparam logic [15:0] RST_SPAN        = 16'hA000;
    localparam logic [7:0]  RST_REF_SRC     = 8'h00;
    localparam logic [7:0]  RST_TSTAMP      = 8'h00;

    // field positions
    localparam int          BIT_ADDR_FREEZE = 0;
    localparam int          BIT_PROC_ON     = 6;
    localparam int          BIT_RECV_ON     = 5;
    localparam int          BIT_MAGNIFY     = 4;
    localparam int          SEL_MSB         = 3;
    localparam int          BIT_SCLK_PECL   = 2;
    localparam int          BIT_STB_PECL    = 1;
    localparam int          BIT_STB_FLIP    = 0;
    localparam int          BIT_REF_BYPASS  = 0;
    localparam int          BIT_TS_PECL     = 1;
    localparam int          BIT_TS_RECV     = 0;

    // serial engine states
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_INSTR = 2'b01,
        ST_DATA  = 2'b10
    } adcscr_state_t;
endpackage

// ### adcscr_regs.sv
`timescale 1ns/100ps
// Summary of operation
// - freeze bit clear: ascend select input picks address step direction while streaming.
// - freeze bit set: address stays fixed for the whole streaming transfer.
// - strobe events are processed only while processor enable bit 6 is set.
// - bit 5 switches the strobe receiver on; cleared at reset.
// - bit 4 switches the edge position status to magnified resolution.
// - bits 3-0 choose the strobe delay tap applied to the strobe.
// - delay select zero means automatic strobe timing calibration.
// - read-only 24-bit edge position status; value after reset undefined.
// - 16-bit span code for input A, reset 0xA000, read and write.
// - 16-bit span code for input B at 0x032-0x033, reset 0xA000.
module adcscr_regs (
    input  wire logic        mclk,                  // 10 MHz system clock
    input  wire logic        arst_n,                // async reset, active low
    input  wire logic        spi_cs_n,              // serial select, active low
    input  wire logic        spi_sclk,              // serial clock, idles low
    input  wire logic        spi_sdi,               // serial data in
    output logic             spi_sdo,               // serial data out
    output logic             spi_sdo_oe,            // high while sdo is driven
    input  wire logic        address_ascend_select, // 1 ascend, 0 descend
    input  wire logic        strobe_pin,            // raw strobe input
    input  wire logic [23:0] strobe_edge_position,  // edge position from capture logic
    output logic             strobe_receiver_on,    // receiver enable
    output logic             strobe_processor_on,   // processor enable
    output logic             strobe_status_magnify, // zoomed status resolution
    output logic      [3:0]  strobe_delay_select,   // selected delay tap
    output logic             strobe_auto_cal,       // automatic timing calibration
    output logic             strobe_event,          // processed strobe edge pulse
    output logic             sample_clock_pecl_mode,// sample clock PECL mode
    output logic             strobe_pecl_mode,      // strobe PECL mode
    output logic             strobe_polarity_flip,  // strobe inverted
    output logic      [15:0] input_a_span_code,     // span code input A
    output logic      [15:0] input_b_span_code,     // span code input B
    output logic             reference_bypass,      // external reference select
    output logic             timestamp_pecl_mode,   // timestamp PECL mode
    output logic             timestamp_receiver_on  // timestamp receiver enable
);
    logic [3:0]  pins_s;
    logic        cs_s;
    logic        sclk_s;
    logic        sdi_s;
    logic        strobe_s;
    logic        sclk_d_q;
    logic        rise;
    logic        fall;
    adcscr_pkg::adcscr_state_t state_q;
    logic [3:0]  cnt_q;
    logic [14:0] shift_q;
    logic        rw_q;
    logic [14:0] addr_q;
    logic [14:0] step_addr;
    logic [14:0] load_addr;
    logic        instr_done;
    logic        byte_done;
    logic        wr_en;
    logic [7:0]  wr_data;
    logic [7:0]  rd_byte;
    logic [7:0]  tx_q;
    logic        sdo_q;
    logic [7:0]  serial_cfg_q;
    logic [7:0]  clk_sysref_q;
    logic [7:0]  clk_mode_q;
    logic [15:0] span_a_q;
    logic [15:0] span_b_q;
    logic [7:0]  ref_src_q;
    logic [7:0]  tstamp_q;
    logic        strobe_rx_q;
    logic        strobe_rx_d_q;
    logic        event_q;

    adcscr_sync #(
        .W (4)
    ) u_sync (
        .mclk   (mclk),
        .arst_n (arst_n),
        .din    ({~spi_cs_n, spi_sclk, spi_sdi, strobe_pin}),
        .dout   (pins_s)
    );

    assign {cs_s, sclk_s, sdi_s, strobe_s} = {~pins_s[3], pins_s[2:0]}; // select synced inverted: reset reads idle

    // serial clock edges seen from mclk; sclk phases must span two mclk periods
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            sclk_d_q <= 1'b0;
        else
            sclk_d_q <= sclk_s;
    end

    assign rise       = sclk_s & ~sclk_d_q & ~cs_s;
    assign fall       = ~sclk_s & sclk_d_q & ~cs_s;
    assign instr_done = rise && state_q == adcscr_pkg::ST_INSTR && cnt_q == adcscr_pkg::INSTR_LAST_BIT;
    assign byte_done  = rise && state_q == adcscr_pkg::ST_DATA && cnt_q == adcscr_pkg::BYTE_LAST_BIT;
    assign wr_en      = byte_done & ~rw_q;
    assign wr_data    = {shift_q[6:0], sdi_s};

    // streaming address step
    always_comb
    begin
        if (serial_cfg_q[adcscr_pkg::BIT_ADDR_FREEZE])
            step_addr = addr_q;
        else if (address_ascend_select)
            step_addr = addr_q + 15'h0001;
        else
            step_addr = addr_q - 15'h0001;
        load_addr = instr_done ? {shift_q[13:0], sdi_s} : step_addr;
    end

    // frame sequencer: instruction of 16 bits then data bytes until deselect
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= adcscr_pkg::ST_IDLE;
            cnt_q   <= 4'h0;
            shift_q <= 15'h0000;
            rw_q    <= 1'b0;
            addr_q  <= 15'h0000;
        end
        else if (cs_s)
        begin
            state_q <= adcscr_pkg::ST_IDLE;
            cnt_q   <= 4'h0;
        end
        else
        begin
            unique case (state_q)
                adcscr_pkg::ST_IDLE:
                    state_q <= adcscr_pkg::ST_INSTR;
                adcscr_pkg::ST_INSTR:
                    if (rise)
                    begin
                        shift_q <= {shift_q[13:0], sdi_s};
                        cnt_q   <= cnt_q + 4'h1;
                        if (instr_done)
                        begin
                            rw_q    <= shift_q[14];
                            addr_q  <= load_addr;
                            cnt_q   <= 4'h0;
                            state_q <= adcscr_pkg::ST_DATA;
                        end
                    end
                adcscr_pkg::ST_DATA:
                    if (rise)
                    begin
                        shift_q <= {shift_q[13:0], sdi_s};
                        cnt_q   <= byte_done ? 4'h0 : cnt_q + 4'h1;
                        if (byte_done)
                            addr_q <= load_addr;
                    end
                default:
                    state_q <= adcscr_pkg::ST_IDLE;
            endcase
        end
    end

    // read mux; unmapped and reserved addresses read zero
    always_comb
    begin
        unique case (load_addr)
            adcscr_pkg::OFS_SERIAL_CFG: rd_byte = serial_cfg_q;
            adcscr_pkg::OFS_CLK_SYSREF: rd_byte = clk_sysref_q;
            adcscr_pkg::OFS_CLK_MODE:   rd_byte = clk_mode_q;
            adcscr_pkg::OFS_POS_B0:     rd_byte = strobe_edge_position[7:0];
            adcscr_pkg::OFS_POS_B1:     rd_byte = strobe_edge_position[15:8];
            adcscr_pkg::OFS_POS_B2:     rd_byte = strobe_edge_position[23:16];
            adcscr_pkg::OFS_SPAN_A_B0:  rd_byte = span_a_q[7:0];
            adcscr_pkg::OFS_SPAN_A_B1:  rd_byte = span_a_q[15:8];
            adcscr_pkg::OFS_SPAN_B_B0:  rd_byte = span_b_q[7:0];
            adcscr_pkg::OFS_SPAN_B_B1:  rd_byte = span_b_q[15:8];
            adcscr_pkg::OFS_REF_SRC:    rd_byte = ref_src_q;
            adcscr_pkg::OFS_TSTAMP:     rd_byte = tstamp_q;
            default:                    rd_byte = 8'h00;
        endcase
    end

    // read shifter: load on the rising edge, present msb first on falling edges
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_q  <= 8'h00;
            sdo_q <= 1'b0;
        end
        else if ((instr_done && shift_q[14]) || (byte_done && rw_q))
            tx_q <= rd_byte;
        else if (fall && state_q == adcscr_pkg::ST_DATA && rw_q)
        begin
            sdo_q <= tx_q[7];
            tx_q  <= {tx_q[6:0], 1'b0};
        end
    end

    assign spi_sdo    = sdo_q;
    assign spi_sdo_oe = (state_q == adcscr_pkg::ST_DATA) & rw_q & ~cs_s;

    // serial access configuration; reserved bits are stored as written
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            serial_cfg_q <= adcscr_pkg::RST_SERIAL_CFG;
        else if (wr_en && addr_q == adcscr_pkg::OFS_SERIAL_CFG)
            serial_cfg_q <= wr_data;
    end

    // clock and strobe control registers
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clk_sysref_q <= adcscr_pkg::RST_CLK_SYSREF;
            clk_mode_q   <= adcscr_pkg::RST_CLK_MODE;
        end
        else if (wr_en && addr_q == adcscr_pkg::OFS_CLK_SYSREF)
            clk_sysref_q <= wr_data;
        else if (wr_en && addr_q == adcscr_pkg::OFS_CLK_MODE)
            clk_mode_q <= wr_data;
    end

    // span codes, low byte at the lower address
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            span_a_q <= adcscr_pkg::RST_SPAN;
            span_b_q <= adcscr_pkg::RST_SPAN;
        end
        else if (wr_en)
        begin
            if (addr_q == adcscr_pkg::OFS_SPAN_A_B0)
                span_a_q[7:0] <= wr_data;
            if (addr_q == adcscr_pkg::OFS_SPAN_A_B1)
                span_a_q[15:8] <= wr_data;
            if (addr_q == adcscr_pkg::OFS_SPAN_B_B0)
                span_b_q[7:0] <= wr_data;
            if (addr_q == adcscr_pkg::OFS_SPAN_B_B1)
                span_b_q[15:8] <= wr_data;
        end
    end

    // reference and timestamp controls
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ref_src_q <= adcscr_pkg::RST_REF_SRC;
            tstamp_q  <= adcscr_pkg::RST_TSTAMP;
        end
        else if (wr_en && addr_q == adcscr_pkg::OFS_REF_SRC)
            ref_src_q <= wr_data;
        else if (wr_en && addr_q == adcscr_pkg::OFS_TSTAMP)
            tstamp_q <= wr_data;
    end

    // strobe path: receiver gate, polarity, then processor edge detect
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strobe_rx_q   <= 1'b0;
            strobe_rx_d_q <= 1'b0;
            event_q       <= 1'b0;
        end
        else
        begin
            strobe_rx_q   <= clk_sysref_q[adcscr_pkg::BIT_RECV_ON] &
                             (strobe_s ^ clk_mode_q[adcscr_pkg::BIT_STB_FLIP]);
            strobe_rx_d_q <= strobe_rx_q;
            event_q       <= clk_sysref_q[adcscr_pkg::BIT_PROC_ON] &
                             strobe_rx_q & ~strobe_rx_d_q;
        end
    end

    // control fields straight from their registers, except auto calibration, decoded from a zero delay select
    assign strobe_receiver_on     = clk_sysref_q[adcscr_pkg::BIT_RECV_ON];
    assign strobe_processor_on    = clk_sysref_q[adcscr_pkg::BIT_PROC_ON];
    assign strobe_status_magnify  = clk_sysref_q[adcscr_pkg::BIT_MAGNIFY];
    assign strobe_delay_select    = clk_sysref_q[adcscr_pkg::SEL_MSB:0];
    assign strobe_auto_cal        = clk_sysref_q[adcscr_pkg::SEL_MSB:0] == 4'h0;
    assign strobe_event           = event_q;
    assign sample_clock_pecl_mode = clk_mode_q[adcscr_pkg::BIT_SCLK_PECL];
    assign strobe_pecl_mode       = clk_mode_q[adcscr_pkg::BIT_STB_PECL];
    assign strobe_polarity_flip   = clk_mode_q[adcscr_pkg::BIT_STB_FLIP];
    assign input_a_span_code      = span_a_q;
    assign input_b_span_code      = span_b_q;
    assign reference_bypass       = ref_src_q[adcscr_pkg::BIT_REF_BYPASS];
    assign timestamp_pecl_mode    = tstamp_q[adcscr_pkg::BIT_TS_PECL];
    assign timestamp_receiver_on  = tstamp_q[adcscr_pkg::BIT_TS_RECV];

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence s_write(logic [14:0] a);
        wr_en && addr_q == a;
    endsequence

    sequence s_byte_frozen;
        byte_done && serial_cfg_q[adcscr_pkg::BIT_ADDR_FREEZE];
    endsequence

    a_addr_ascend: assert property (byte_done && !serial_cfg_q[0] && address_ascend_select |=>
        addr_q == $past(addr_q) + 15'h0001) else $error("address did not ascend");
    a_addr_descend: assert property (byte_done && !serial_cfg_q[0] && !address_ascend_select |=>
        addr_q == $past(addr_q) - 15'h0001) else $error("address did not descend");
    a_addr_frozen: assert property (s_byte_frozen |=> $stable(addr_q))
        else $error("address moved while frozen");
    a_proc_gate: assert property (event_q |-> $past(clk_sysref_q[6]) && $past(strobe_rx_q))
        else $error("strobe event without processor enable");
    a_recv_gate: assert property (!clk_sysref_q[5] [*2] |=> !event_q && !strobe_rx_q)
        else $error("strobe passed with receiver off");
    a_strobe_flip: assert property (clk_sysref_q[5] && clk_mode_q[0] |=> strobe_rx_q != $past(strobe_s))
        else $error("strobe polarity not inverted");
    a_ctrl_write: assert property (s_write(adcscr_pkg::OFS_CLK_SYSREF) |=>
        strobe_delay_select == $past(wr_data[3:0]) && strobe_status_magnify == $past(wr_data[4]))
        else $error("delay select or magnify not written");
    a_auto_cal: assert property (s_write(adcscr_pkg::OFS_CLK_SYSREF) |=>
        strobe_auto_cal == ($past(wr_data[3:0]) == 4'h0)) else $error("auto calibration not selected at zero");
    a_mode_write: assert property (s_write(adcscr_pkg::OFS_CLK_MODE) |=>
        sample_clock_pecl_mode == $past(wr_data[2]) && strobe_pecl_mode == $past(wr_data[1]))
        else $error("clock mode bits not written");
    a_status_read: assert property (instr_done && shift_q[14] && load_addr == adcscr_pkg::OFS_POS_B0 |=>
        tx_q == $past(strobe_edge_position[7:0])) else $error("edge position byte not loaded");
    a_span_a_write: assert property (s_write(adcscr_pkg::OFS_SPAN_A_B1) |=>
        input_a_span_code[15:8] == $past(wr_data) && $stable(input_a_span_code[7:0]))
        else $error("span A high byte not written");
    a_span_b_write: assert property (s_write(adcscr_pkg::OFS_SPAN_B_B0) |=>
        input_b_span_code[7:0] == $past(wr_data) && $stable(input_b_span_code[15:8]))
        else $error("span B low byte not written");
endmodule

// ### adcscr_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for pins from outside the mclk domain
module adcscr_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,   // system clock
    input  wire logic         arst_n, // async reset, active low
    input  wire logic [W-1:0] din,    // asynchronous inputs
    output logic      [W-1:0] dout    // synchronised outputs
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule

// ### test_adc_sysref_clock_config_regs.sv
`timescale 1ns/100ps
// self-checking bench for the clock and strobe configuration bank
module test_adc_sysref_clock_config_regs;
    logic        mclk, arst_n, spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe;  // clock, reset, serial
    logic        address_ascend_select, strobe_pin, strobe_event;                 // stream and strobe
    logic [23:0] strobe_edge_position;                                            // status source
    logic        strobe_receiver_on, strobe_processor_on, strobe_status_magnify;  // control outputs
    logic [3:0]  strobe_delay_select;                                             // delay tap
    logic        strobe_auto_cal, sample_clock_pecl_mode, strobe_pecl_mode;       // mode outputs
    logic        strobe_polarity_flip, reference_bypass;                          // mode outputs
    logic        timestamp_pecl_mode, timestamp_receiver_on;                      // mode outputs
    logic [15:0] input_a_span_code, input_b_span_code;                            // span codes
    int          failures, samples_checked, cycles;                               // bookkeeping

    adcscr_regs u_dut (
        .mclk(mclk), .arst_n(arst_n), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .address_ascend_select(address_ascend_select),
        .strobe_pin(strobe_pin), .strobe_edge_position(strobe_edge_position),
        .strobe_receiver_on(strobe_receiver_on), .strobe_processor_on(strobe_processor_on),
        .strobe_status_magnify(strobe_status_magnify), .strobe_delay_select(strobe_delay_select),
        .strobe_auto_cal(strobe_auto_cal), .strobe_event(strobe_event),
        .sample_clock_pecl_mode(sample_clock_pecl_mode), .strobe_pecl_mode(strobe_pecl_mode),
        .strobe_polarity_flip(strobe_polarity_flip), .input_a_span_code(input_a_span_code),
        .input_b_span_code(input_b_span_code), .reference_bypass(reference_bypass),
        .timestamp_pecl_mode(timestamp_pecl_mode), .timestamp_receiver_on(timestamp_receiver_on)
    );

    adcscr_host u_host (
        .mclk(mclk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe)
    );

    // 100 ns clock
    always #50 mclk = ~mclk;

    // hang guard: the whole run needs roughly 9.3k cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            failures++;
            final_report;
        end
    end

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask

    task automatic wr(input logic [14:0] addr, input logic [7:0] b);
        u_host.tx[0] = b;
        u_host.xfer(1'b0, addr, 1);
    endtask

    task automatic rdchk(input logic [14:0] addr, input logic [7:0] exp);
        u_host.xfer(1'b1, addr, 1);
        chk($sformatf("register %h", addr), {16'h0000, exp}, {16'h0000, u_host.rx[0]});
    endtask

    // raise the strobe for 10 cycles; count processed events, and those after the pin falls
    task automatic pulse(output int seen, output int late);
        seen = 0;
        late = 0;
        strobe_pin = 1'b1;
        for (int i = 0; i < 20; i++)
        begin
            @(negedge mclk);
            if (strobe_event === 1'b1)
                seen++;
            late += (strobe_event === 1'b1 && i >= 10);
            if (i == 9)
                strobe_pin = 1'b0;
        end
    endtask

    task automatic t_reset;
        logic [14:0] ra [9] = '{15'h0010, 15'h0029, 15'h002a, 15'h0030, 15'h0031, 15'h0032, 15'h0033,
                                15'h0038, 15'h003b};
        logic [7:0]  rv [9] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'ha0, 8'h00, 8'ha0, 8'h00, 8'h00};
        chk("span a", 24'h00_a000, {8'h00, input_a_span_code});
        chk("span b", 24'h00_a000, {8'h00, input_b_span_code});
        chk("strobe ctl", 24'h00_0001, {strobe_receiver_on, strobe_processor_on, strobe_status_magnify,
            strobe_delay_select, strobe_auto_cal});
        for (int i = 0; i < 9; i++)
            rdchk(ra[i], rv[i]);
        $display("test reset values done");
    endtask

    task automatic t_delay;
        for (int v = 0; v < 16; v++)
        begin
            wr(15'h0029, {4'h1, v[3:0]});
            chk("delay tap", {16'h0000, 3'b001, v[3:0], v == 0}, {16'h0000, strobe_receiver_on,
                strobe_processor_on, strobe_status_magnify, strobe_delay_select, strobe_auto_cal});
        end
        wr(15'h002a, 8'h27);
        chk("clock modes", 24'h00_0007, {sample_clock_pecl_mode, strobe_pecl_mode, strobe_polarity_flip});
        rdchk(15'h002a, 8'h27);
        wr(15'h002a, 8'h20);
        chk("clock modes off", 24'h00_0000, {sample_clock_pecl_mode, strobe_pecl_mode, strobe_polarity_flip});
        $display("test delay and modes done");
    endtask

    task automatic t_strobe;
        int seen;
        int late;
        wr(15'h0029, 8'h00);
        pulse(seen, late);
        chk("event while off", 24'h00_0000, seen);
        wr(15'h0029, 8'h20);
        chk("receiver on", 24'h00_0002, {strobe_receiver_on, strobe_processor_on});
        pulse(seen, late);
        chk("event receiver only", 24'h00_0000, seen);
        wr(15'h0029, 8'h60);
        pulse(seen, late);
        chk("event while on", 24'h00_0001, seen);
        chk("event on pin rise", 24'h00_0000, late);
        wr(15'h002a, 8'h21);
        pulse(seen, late);
        chk("event inverted", 24'h00_0001, seen);
        chk("event on pin fall", 24'h00_0001, late);
        wr(15'h002a, 8'h20);
        $display("test strobe done");
    endtask

    task automatic t_stream;
        u_host.tx[0] = 8'h12;
        u_host.tx[1] = 8'h34;
        u_host.xfer(1'b0, 15'h0030, 2);
        chk("span a ascend", 24'h00_3412, {8'h00, input_a_span_code});
        address_ascend_select = 1'b0;
        u_host.tx[0] = 8'h56;
        u_host.tx[1] = 8'h78;
        u_host.xfer(1'b0, 15'h0033, 2);
        chk("span b descend", 24'h00_5678, {8'h00, input_b_span_code});
        wr(15'h0010, 8'h01);
        u_host.tx[0] = 8'h02;
        u_host.tx[1] = 8'h03;
        u_host.xfer(1'b0, 15'h003b, 2);
        chk("frozen address", 24'h00_0003, {reference_bypass, timestamp_pecl_mode, timestamp_receiver_on});
        rdchk(15'h0010, 8'h01);
        wr(15'h0010, 8'h00);
        address_ascend_select = 1'b1;
        $display("test streaming done");
    endtask

    task automatic t_status;
        strobe_edge_position = 24'h12_3456;
        u_host.xfer(1'b1, 15'h002c, 3);
        chk("edge position", 24'h12_3456, {u_host.rx[2], u_host.rx[1], u_host.rx[0]});
        wr(15'h002c, 8'hff);
        rdchk(15'h002c, 8'h56);
        wr(15'h0029, {4'h6, u_host.rx[0][3:0]});
        chk("manual tap", 24'h00_0006, {20'h0_0000, strobe_delay_select});
        rdchk(15'h002b, 8'h00);
        $display("test status done");
    endtask

    task automatic final_report;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // reset for 6 cycles, let the synchronisers settle, then run each test
    initial
    begin
        mclk = 1'b0;
        arst_n = 1'b0;
        address_ascend_select = 1'b1;
        strobe_pin = 1'b0;
        strobe_edge_position = 24'h00_0000;
        failures = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (6) @(negedge mclk);
        arst_n = 1'b1;
        repeat (4) @(negedge mclk);
        t_reset;
        t_delay;
        t_strobe;
        t_stream;
        t_status;
        final_report;
    end
endmodule
